// ### twi_pkg.sv
// shared constants, types and helpers of the two-wire bus controller
package twi_pkg;

  // register offsets on the plain register port
  localparam logic [2:0] OFS_OWN_ADDR = 3'h0;
  localparam logic [2:0] OFS_LOW_CNT  = 3'h1;
  localparam logic [2:0] OFS_HIGH_CNT = 3'h2;
  localparam logic [2:0] OFS_CTRL     = 3'h3;
  localparam logic [2:0] OFS_STATUS   = 3'h4;
  localparam logic [2:0] OFS_DATA     = 3'h5;
  localparam logic [2:0] OFS_IRQ_ST   = 3'h6;
  localparam logic [2:0] OFS_IRQ_MASK = 3'h7;

  // status register bit positions
  localparam int ST_RECEIVED_ACK_FLAG = 0;
  localparam int ST_SRW  = 2;
  localparam int ST_TX   = 3;
  localparam int ST_ARB  = 4;
  localparam int ST_BUSY = 5;
  localparam int ST_AAS  = 6;
  localparam int ST_HOLD = 7;

  // interrupt status and mask bit positions
  localparam int IRQ_BYTE = 0;
  localparam int IRQ_ARB  = 1;

  // scl timing at the 50 MHz system clock
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCL_LOW_NS    = 5000;
  localparam int SCL_HIGH_NS   = 5000;
  localparam int LOW_CYCLES    = (SCL_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HIGH_CYCLES   = (SCL_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // reset values and bit counter codes
  localparam logic [7:0] LOW_CNT_RST   = 8'(LOW_CYCLES);
  localparam logic [7:0] HIGH_CNT_RST  = 8'(HIGH_CYCLES);
  localparam logic [6:0] OWN_ADDR_RST  = 7'h00;
  localparam logic [7:0] CTRL_RST      = 8'h00;
  localparam logic [1:0] IRQ_MASK_RST  = 2'h0;
  localparam logic [3:0] BIT_PRE       = 4'hF;
  localparam logic [3:0] BIT_ACK       = 4'h8;

  // control register: master select $20, no-ack $08, repeat start $04
  typedef struct packed {
    logic       enable;
    logic       unused6;
    logic       master_sel;
    logic       tx_mode;
    logic       no_ack_enable;
    logic       repeat_start;
    logic [1:0] unused10;
  } ctrl_t;

  // one bit per bus line
  typedef struct packed {
    logic scl;
    logic sda;
  } line_t;

  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_START = 3'h1,
    S_HOLD  = 3'h3,
    S_XFER  = 3'h2,
    S_RSTA  = 3'h6,
    S_STOP  = 3'h7
  } state_t;

  typedef enum logic [1:0] {
    T_LOW  = 2'h0,
    T_WAIT = 2'h1,
    T_HIGH = 2'h3
  } tmr_state_t;

  // true in the last cycle of a count of lim cycles
  function automatic logic count_done(input logic [7:0] cnt,
                                      input logic [7:0] lim);
    return ({1'b0, cnt} + 9'h001) >= {1'b0, lim};
  endfunction

endpackage

// ### pin_sync.sv
// two-flop synchroniser for bus pin inputs
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int         W   = 2,
  parameter logic [W-1:0] RST = '1
) (
  input  wire logic         sys_clk, // system clock
  input  wire logic         srst,    // synchronous reset
  input  wire logic [W-1:0] d,       // asynchronous pin levels
  output var  logic [W-1:0] q        // synchronised levels
);
  logic [W-1:0] meta;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta <= RST;
      q    <= RST;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// ### scl_timer.sv
// scl low/high timer with wired-and clock synchronisation
`timescale 1ns/100ps
`default_nettype none
module scl_timer (
  input  wire logic       sys_clk,  // system clock
  input  wire logic       srst,     // synchronous reset
  input  wire logic       run,      // master clocking a byte
  input  wire logic       scl_s,    // synchronised scl level
  input  wire logic       scl_fall, // scl falling edge seen
  input  wire logic [7:0] low_cnt,  // low period in cycles
  input  wire logic [7:0] high_cnt, // high period in cycles
  output logic            scl_low   // drive scl low
);
  import twi_pkg::*;

  tmr_state_t ts;
  logic [7:0] cnt;

  always_ff @(posedge sys_clk) begin
    if (srst || !run) begin
      ts  <= T_LOW;
      cnt <= 8'h00;
    end else begin
      unique case (ts)
        T_LOW: begin
          if (scl_fall) begin
            cnt <= 8'h00;
          end else if (count_done(cnt, low_cnt)) begin
            ts  <= T_WAIT;
            cnt <= 8'h00;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        T_WAIT: begin
          cnt <= 8'h00;
          if (scl_s) begin
            ts <= T_HIGH;
          end
        end
        T_HIGH: begin
          if (scl_fall || count_done(cnt, high_cnt)) begin
            ts  <= T_LOW;
            cnt <= 8'h00;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        default: begin
          ts  <= T_LOW;
          cnt <= 8'h00;
        end
      endcase
    end
  end

  assign scl_low = run && (ts == T_LOW);

  a_low_after_fall: assert property (@(posedge sys_clk) disable iff (srst)
    (run && scl_fall && ts != T_WAIT) ##1 run |-> scl_low)
    else $error("scl not held low after falling edge");

  a_wait_for_rise: assert property (@(posedge sys_clk) disable iff (srst)
    (run && ts == T_WAIT && !scl_s) |=> (ts != T_HIGH && !scl_low))
    else $error("high count started while scl still low");

  a_high_then_low: assert property (@(posedge sys_clk) disable iff (srst)
    (run && ts == T_HIGH && count_done(cnt, high_cnt)) ##1 run |-> scl_low)
    else $error("scl not pulled low after high period");
endmodule
`default_nettype wire

// ### twi_ctrl.sv
// two-wire bus controller, master and slave, with register port
// Notes on behaviour
// - master losing a one-bit detects lost arbitration
// - loser becomes slave, frees sda, no stop
// - hardware flags arbitration loss for software
// - bus low is longest, high is shortest
// - after any scl fall hold low period
// - wait for real scl rise before high
// - after high count pull scl low again
// - master can issue repeated start on bus
// - repeat-start bit starts, software writes address
// - clearing master select generates a stop
// - control register write clears addressed flag
// - addressed flag only at address-match interrupt
// - slave data write transmits, dummy read receives
// - slave holds scl low until data access
`timescale 1ns/100ps
`default_nettype none
module twi_ctrl (
  input  wire logic          sys_clk,   // system clock, 50 MHz
  input  wire logic          srst,      // synchronous reset, high
  input  wire logic [2:0]    reg_addr,  // register offset
  input  wire logic [7:0]    reg_wdata, // register write data
  input  wire logic          reg_wr,    // write strobe
  input  wire logic          reg_rd,    // read strobe
  output logic [7:0]         reg_rdata, // read data, cycle after strobe
  input  wire twi_pkg::line_t bus_in,   // scl/sda pin levels
  output twi_pkg::line_t     bus_out,   // scl/sda output values
  output twi_pkg::line_t     bus_oe,    // high while pulling line low
  output logic               irq        // level interrupt
);
  import twi_pkg::*;

  line_t      bus_s;
  logic       scl_q;
  logic       sda_q;
  ctrl_t      ctrl;
  logic [6:0] own_addr;
  logic [7:0] low_cnt;
  logic [7:0] high_cnt;
  logic [7:0] tx_data;
  logic [7:0] rx_data;
  logic [7:0] shift;
  logic [1:0] irq_st;
  logic [1:0] irq_mask;
  state_t     st;
  logic [1:0] ph;
  logic [7:0] gcnt;
  logic [3:0] bit_cnt;
  logic       is_master;
  logic       addr_phase;
  logic       sda_low;
  logic       aas;
  logic       target_read_write_flag;
  logic       received_ack_flag;
  logic       busy;
  logic       go;
  logic       msel_q;
  logic       tmr_low;
  logic [7:0] stat;

  pin_sync #(.W(2), .RST(2'h3)) u_sync (
    .sys_clk (sys_clk),
    .srst    (srst),
    .d       (bus_in),
    .q       (bus_s)
  );

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= bus_s.scl;
      sda_q <= bus_s.sda;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise  = bus_s.scl && !scl_q;
  assign scl_fall  = !bus_s.scl && scl_q;
  assign start_det = scl_q && bus_s.scl && sda_q && !bus_s.sda;
  assign stop_det  = scl_q && bus_s.scl && !sda_q && bus_s.sda;

  // register strobes
  logic wr_ctrl, wr_data, rd_data, wr_irq, go_req;
  assign wr_ctrl = reg_wr && reg_addr == OFS_CTRL;
  assign wr_data = reg_wr && reg_addr == OFS_DATA;
  assign rd_data = reg_rd && reg_addr == OFS_DATA;
  assign wr_irq  = reg_wr && reg_addr == OFS_IRQ_ST;
  assign go_req  = (wr_data && ctrl.tx_mode) || (rd_data && !ctrl.tx_mode);

  // byte direction, acknowledge and event terms
  logic xmit, match, ack_low, arb_ev, byte_end;
  logic master_req, start_ok, start_refused, arb_set;
  logic [7:0] gen_lim;
  assign xmit     = addr_phase ? is_master : ctrl.tx_mode;
  assign match    = shift[7:1] == own_addr;
  assign ack_low  = !xmit && (addr_phase ? match : !ctrl.no_ack_enable);
  assign arb_ev   = st == S_XFER && is_master && xmit && bit_cnt < BIT_ACK
                    && scl_rise && !sda_low && !bus_s.sda;
  assign byte_end = st == S_XFER && scl_fall && bit_cnt == BIT_ACK;
  assign master_req    = ctrl.master_sel && !msel_q;
  assign start_ok      = master_req && st == S_IDLE && !busy && ctrl.enable;
  assign start_refused = master_req && !start_ok;
  assign arb_set       = arb_ev || start_refused;
  assign gen_lim  = (ph == 2'h0 && st != S_START) ? low_cnt : high_cnt;

  scl_timer u_timer (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .run      (st == S_XFER && is_master),
    .scl_s    (bus_s.scl),
    .scl_fall (scl_fall),
    .low_cnt  (low_cnt),
    .high_cnt (high_cnt),
    .scl_low  (tmr_low)
  );

  // byte and bus-condition sequencer
  always_ff @(posedge sys_clk) begin
    if (srst || !ctrl.enable) begin
      st         <= S_IDLE;
      ph         <= 2'h0;
      gcnt       <= 8'h00;
      bit_cnt    <= 4'h0;
      shift      <= 8'h00;
      rx_data    <= 8'h00;
      is_master  <= 1'b0;
      addr_phase <= 1'b0;
      sda_low    <= 1'b0;
    end else begin
      unique case (st)
        S_IDLE: begin
          if (start_ok) begin
            st        <= S_START;
            is_master <= 1'b1;
            ph        <= 2'h0;
            gcnt      <= 8'h00;
            sda_low   <= 1'b1;
          end else if (start_det) begin
            st         <= S_XFER;
            addr_phase <= 1'b1;
            bit_cnt    <= BIT_PRE;
            shift      <= 8'hFF;
            sda_low    <= 1'b0;
          end
        end
        S_START: begin
          if (count_done(gcnt, gen_lim)) begin
            st         <= S_HOLD;
            addr_phase <= 1'b1;
            gcnt       <= 8'h00;
          end else begin
            gcnt <= gcnt + 8'h01;
          end
        end
        S_HOLD: begin
          if (is_master && !ctrl.master_sel) begin
            st      <= S_STOP;
            ph      <= 2'h0;
            gcnt    <= 8'h00;
            sda_low <= 1'b1;
          end else if (is_master && ctrl.repeat_start) begin
            st      <= S_RSTA;
            ph      <= 2'h0;
            gcnt    <= 8'h00;
            sda_low <= 1'b0;
          end else if (go && !scl_q) begin // own scl fall already seen
            st      <= S_XFER;
            bit_cnt <= 4'h0;
            shift   <= xmit ? tx_data : 8'hFF;
            sda_low <= xmit && !tx_data[7];
          end
        end
        S_XFER: begin
          if (!is_master && stop_det) begin
            st      <= S_IDLE;
            sda_low <= 1'b0;
          end else if (!is_master && start_det) begin
            addr_phase <= 1'b1;
            bit_cnt    <= BIT_PRE;
            shift      <= 8'hFF;
            sda_low    <= 1'b0;
          end else if (scl_rise && bit_cnt < BIT_ACK) begin
            shift <= {shift[6:0], bus_s.sda};
            if (arb_ev) begin
              is_master <= 1'b0;
              sda_low   <= 1'b0;
              if (!addr_phase) begin
                st <= S_IDLE;
              end
            end
          end else if (scl_fall) begin
            if (bit_cnt == BIT_PRE) begin
              bit_cnt <= 4'h0;
            end else if (bit_cnt < 4'h7) begin
              bit_cnt <= bit_cnt + 4'h1;
              sda_low <= xmit && !shift[7];
            end else if (bit_cnt == 4'h7) begin
              bit_cnt <= BIT_ACK;
              rx_data <= shift;
              sda_low <= ack_low;
              if (addr_phase && !is_master && !match) begin
                st      <= S_IDLE;
                sda_low <= 1'b0;
              end
            end else begin
              st         <= S_HOLD;
              sda_low    <= 1'b0;
              addr_phase <= 1'b0;
            end
          end
        end
        S_RSTA, S_STOP: begin
          if (ph == 2'h1 && !bus_s.scl) begin
            gcnt <= 8'h00;
          end else if (count_done(gcnt, gen_lim)) begin
            gcnt <= 8'h00;
            ph   <= ph + 2'h1;
            if (ph == 2'h1) begin
              sda_low <= st == S_RSTA;
            end
            if (ph == 2'h2) begin
              st         <= st == S_RSTA ? S_HOLD : S_IDLE;
              addr_phase <= st == S_RSTA;
              is_master  <= st == S_RSTA;
              sda_low    <= st == S_RSTA;
              ph         <= 2'h0;
            end
          end else begin
            gcnt <= gcnt + 8'h01;
          end
        end
        default: begin
          st <= S_IDLE;
        end
      endcase
    end
  end

  // software registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl     <= CTRL_RST;
      own_addr <= OWN_ADDR_RST;
      low_cnt  <= LOW_CNT_RST;
      high_cnt <= HIGH_CNT_RST;
      tx_data  <= 8'h00;
      irq_mask <= IRQ_MASK_RST;
      msel_q   <= 1'b0;
    end else begin
      msel_q <= ctrl.master_sel;
      if (wr_ctrl) begin
        ctrl <= reg_wdata;
      end else begin
        if (arb_set) begin
          ctrl.master_sel <= 1'b0;
        end
        if (st == S_RSTA) begin
          ctrl.repeat_start <= 1'b0;
        end
      end
      if (reg_wr && reg_addr == OFS_OWN_ADDR) begin
        own_addr <= reg_wdata[7:1];
      end
      if (reg_wr && reg_addr == OFS_LOW_CNT) begin
        low_cnt <= reg_wdata;
      end
      if (reg_wr && reg_addr == OFS_HIGH_CNT) begin
        high_cnt <= reg_wdata;
      end
      if (wr_data) begin
        tx_data <= reg_wdata;
      end
      if (reg_wr && reg_addr == OFS_IRQ_MASK) begin
        irq_mask <= reg_wdata[1:0];
      end
    end
  end

  // sticky interrupt status, write one to clear, set wins
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_st <= 2'h0;
    end else begin
      irq_st[IRQ_BYTE] <= byte_end
        || (irq_st[IRQ_BYTE] && !(wr_irq && reg_wdata[IRQ_BYTE]));
      irq_st[IRQ_ARB]  <= arb_set
        || (irq_st[IRQ_ARB] && !(wr_irq && reg_wdata[IRQ_ARB]));
    end
  end

  // transfer flags seen by software
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      aas  <= 1'b0;
      target_read_write_flag  <= 1'b0;
      received_ack_flag <= 1'b0;
      busy <= 1'b0;
      go   <= 1'b0;
    end else begin
      if (byte_end && addr_phase && !is_master) begin
        aas <= 1'b1;
        target_read_write_flag <= shift[0];
      end else if (wr_ctrl || byte_end) begin
        aas <= 1'b0;
      end
      if (st == S_XFER && scl_rise && bit_cnt == BIT_ACK && xmit) begin
        received_ack_flag <= bus_s.sda;
      end
      if (start_det) begin
        busy <= 1'b1;
      end else if (stop_det) begin
        busy <= 1'b0;
      end
      if (st == S_IDLE || st == S_XFER || st == S_STOP) begin
        go <= 1'b0;
      end else begin
        go <= go || go_req;
      end
    end
  end

  always_comb begin
    stat          = 8'h00;
    stat[ST_RECEIVED_ACK_FLAG] = received_ack_flag;
    stat[ST_SRW]  = target_read_write_flag;
    stat[ST_TX]   = is_master;
    stat[ST_ARB]  = irq_st[IRQ_ARB];
    stat[ST_BUSY] = busy;
    stat[ST_AAS]  = aas;
    stat[ST_HOLD] = st == S_HOLD;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_OWN_ADDR: reg_rdata <= {own_addr, 1'b0};
        OFS_LOW_CNT:  reg_rdata <= low_cnt;
        OFS_HIGH_CNT: reg_rdata <= high_cnt;
        OFS_CTRL:     reg_rdata <= ctrl;
        OFS_STATUS:   reg_rdata <= stat;
        OFS_DATA:     reg_rdata <= rx_data;
        OFS_IRQ_ST:   reg_rdata <= {6'h00, irq_st};
        OFS_IRQ_MASK: reg_rdata <= {6'h00, irq_mask};
      endcase
    end
  end

  assign irq         = |(irq_st & irq_mask);
  assign bus_out     = '0;
  assign bus_oe.sda  = sda_low;
  assign bus_oe.scl  = st == S_HOLD
                    || (st == S_XFER && is_master && tmr_low)
                    || ((st == S_RSTA || st == S_STOP) && ph == 2'h0);

  a_arb_release: assert property (@(posedge sys_clk) disable iff (srst)
    arb_ev |=> (!is_master && !bus_oe.sda && st != S_STOP))
    else $error("lost master still drives sda or stops");
  a_arb_flag: assert property (@(posedge sys_clk) disable iff (srst)
    arb_ev |=> (irq_st[IRQ_ARB] && !ctrl.master_sel))
    else $error("arbitration loss not flagged");
  a_ctrl_clears: assert property (@(posedge sys_clk) disable iff (srst)
    (wr_ctrl && !(byte_end && addr_phase && !is_master)) |=> !aas)
    else $error("control write left addressed flag set");
  a_stop_start: assert property (@(posedge sys_clk) disable iff (srst)
    (st == S_HOLD && is_master && !ctrl.master_sel && ctrl.enable)
    |=> (st == S_STOP && bus_oe.sda) ##1 bus_oe.scl)
    else $error("stop not started after master select cleared");
  a_rsta_start: assert property (@(posedge sys_clk) disable iff (srst)
    (st == S_HOLD && is_master && ctrl.master_sel && ctrl.repeat_start
     && ctrl.enable) |=> (st == S_RSTA && !bus_oe.sda))
    else $error("repeated start not begun");
  a_slave_hold: assert property (@(posedge sys_clk) disable iff (srst)
    (st == S_HOLD && !is_master && !go) |-> bus_oe.scl ##1 bus_oe.scl)
    else $error("slave released scl without data access");
  a_slave_go: assert property (@(posedge sys_clk) disable iff (srst)
    (st == S_HOLD && !is_master && go_req && ctrl.enable)
    |=> ##[0:1] st == S_XFER)
    else $error("slave data access did not start a byte");
  a_byte_irq: assert property (@(posedge sys_clk) disable iff (srst)
    (byte_end && irq_mask[IRQ_BYTE]) |=> irq)
    else $error("byte end raised no interrupt");
endmodule
`default_nettype wire

// ### bus_agent.sv
// far-side bus party: target device, rival master and test master
`timescale 1ns/100ps
`default_nettype none
module bus_agent (
  input  wire logic scl,    // resolved clock line
  input  wire logic sda,    // resolved data line
  output logic      scl_oe, // pulls clock low
  output logic      sda_oe  // pulls data low
);
  logic       slv_en = 1'b0;
  logic       slow   = 1'b0;
  logic       grab   = 1'b0;
  logic [7:0] sh;
  logic [7:0] got[$];
  int         cnt    = 0;
  int         starts = 0;
  int         stops  = 0;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  always @(negedge sda) if (scl) begin
    cnt = 0;
    starts++;
  end
  always @(posedge sda) if (scl) stops++;
  always @(posedge scl) if (slv_en && cnt >= 1 && cnt <= 8) sh = {sh[6:0], sda};
  always @(negedge scl) if (slv_en) begin
    cnt++;
    if (grab && cnt == 1) sda_oe = 1'b1;
    else if (!grab && cnt == 9) begin
      sda_oe = 1'b1;
      got.push_back(sh);
    end
    else if (!grab && cnt == 10) begin
      sda_oe = 1'b0;
      cnt = 1;
    end
    if (slow) begin
      scl_oe = 1'b1;
      #600 scl_oe = 1'b0;
    end
  end
  // one bit as master, 160 ns, waits while clock is stretched
  task automatic bitx(input logic b, output logic r);
    #40 sda_oe = ~b;
    #40 scl_oe = 1'b0;
    wait (scl);
    #80 r = sda;
    scl_oe = 1'b1;
  endtask
  task automatic start_c();
    sda_oe = 1'b0;
    #40 scl_oe = 1'b0;
    wait (scl);
    #80 sda_oe = 1'b1;
    #80 scl_oe = 1'b1;
  endtask
  task automatic byte_x(input logic [7:0] d, input logic last,
                        output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(last, ack);
  endtask
  task automatic stop_c();
    #40 sda_oe = 1'b1;
    #40 scl_oe = 1'b0;
    wait (scl);
    #80 sda_oe = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### twi_ctrl_tb.sv
// self-checking bench of the two-wire bus controller
`timescale 1ns/100ps
`default_nettype none
module twi_ctrl_tb;
  import twi_pkg::*;
  logic        sys_clk   = 1'b0;
  logic        srst      = 1'b1;
  logic [2:0]  reg_addr  = 3'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        rd_q      = 1'b0;
  logic [7:0]  reg_rdata;
  line_t       bus_in;
  line_t       bus_out;
  line_t       bus_oe;
  logic        irq, scl, sda, a_scl, a_sda, ack;
  logic [7:0]  q, dat;
  logic [15:0] e;
  logic [15:0] expq[$];
  int          n_fail = 0;
  int          samples_checked = 0;
  int          n, st0, st1;
  int          n_low = 0;
  always #10 sys_clk = ~sys_clk;
  // data low at a clock rise: acks while nobody else drives
  always @(posedge scl) if (!sda) n_low++;
  assign scl = ~(bus_oe.scl | a_scl);
  assign sda = ~(bus_oe.sda | a_sda);
  assign bus_in = {scl, sda};
  twi_ctrl dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bus_in(bus_in), .bus_out(bus_out),
    .bus_oe(bus_oe), .irq(irq));
  bus_agent agent (.scl(scl), .sda(sda), .scl_oe(a_scl), .sda_oe(a_sda));
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] v,
                    input logic [7:0] m);
    expq.push_back({m, v});
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wait_irq();
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    chk(irq === 1'b1, "no interrupt");
  endtask
  // oldest noted read result against the data after each read
  always @(posedge sys_clk) begin
    if (rd_q) begin
      e = expq.pop_front();
      chk((reg_rdata & e[15:8]) === (e[7:0] & e[15:8]), "read data");
    end
    rd_q <= reg_rd;
  end
  initial begin
    void'($urandom(32'he7aa));
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    rd(OFS_LOW_CNT, LOW_CNT_RST, 8'hFF);
    rd(OFS_HIGH_CNT, HIGH_CNT_RST, 8'hFF);
    rd(OFS_CTRL, CTRL_RST, 8'hFF);
    rd(OFS_IRQ_MASK, {6'h00, IRQ_MASK_RST}, 8'hFF);
    wr(OFS_STATUS, 8'($urandom));
    rd(OFS_STATUS, 8'h00, 8'hFE);
    chk(bus_out === 2'b00, "line values");
    wr(OFS_LOW_CNT, 8'h04);
    wr(OFS_HIGH_CNT, 8'h04);
    wr(OFS_OWN_ADDR, 8'hA4);
    rd(OFS_OWN_ADDR, 8'hA4, 8'hFF);
    wr(OFS_IRQ_MASK, 8'h03);
    wr(OFS_CTRL, 8'h80);
    $display("registers done");
    agent.slv_en = 1'b1;
    for (int s = 0; s < 2; s++) begin
      agent.slow = s[0];
      st0 = agent.stops;
      st1 = agent.starts;
      dat = 8'($urandom);
      wr(OFS_CTRL, 8'hB0);
      wr(OFS_DATA, 8'h74);
      wait_irq();
      rd(OFS_STATUS, 8'h08, 8'h09);
      wr(OFS_IRQ_ST, 8'h01);
      chk(irq === 1'b0, "irq clear");
      wr(OFS_DATA, dat);
      wait_irq();
      wr(OFS_IRQ_ST, 8'h01);
      wr(OFS_CTRL, 8'hB4);
      wr(OFS_DATA, 8'h74);
      wait_irq();
      wr(OFS_IRQ_ST, 8'h01);
      chk(agent.stops == st0, "stop before restart");
      wr(OFS_CTRL, 8'h90);
      n = 0;
      while (agent.stops == st0 && n < 3000) begin
        @(posedge sys_clk);
        n++;
      end
      chk(agent.stops == st0 + 1 && agent.starts == st1 + 2, "stop");
      chk(agent.got.size() == 3 && agent.got[0] === 8'h74 &&
          agent.got[1] === dat && agent.got[2] === 8'h74, "bytes");
      repeat (4) @(posedge sys_clk);
      rd(OFS_STATUS, 8'h00, 8'h28);
      agent.got.delete();
    end
    $display("master done");
    agent.slow = 1'b0;
    agent.grab = 1'b1;
    st0 = agent.stops;
    wr(OFS_CTRL, 8'hB0);
    wr(OFS_DATA, 8'hC6);
    wait_irq();
    rd(OFS_IRQ_ST, 8'h02, 8'h02);
    rd(OFS_STATUS, 8'h10, 8'h18);
    chk(bus_oe.sda === 1'b0 && agent.stops == st0, "loser");
    agent.grab = 1'b0;
    agent.slv_en = 1'b0;
    agent.sda_oe = 1'b0;
    wr(OFS_IRQ_ST, 8'h03);
    chk(irq === 1'b0, "irq clear");
    $display("arbitration done");
    repeat (4) @(posedge sys_clk);
    wr(OFS_CTRL, 8'hB0);
    wr(OFS_DATA, 8'hA5);
    wait_irq();
    wr(OFS_IRQ_ST, 8'h01);
    wr(OFS_CTRL, 8'hA0);
    n_low = 0;
    rd(OFS_DATA, 8'h00, 8'h00);
    wait_irq();
    wr(OFS_IRQ_ST, 8'h01);
    wr(OFS_CTRL, 8'hA8);
    rd(OFS_DATA, 8'hFF, 8'hFF);
    wait_irq();
    chk(n_low == 1, "master rx ack");
    wr(OFS_IRQ_ST, 8'h01);
    st0 = agent.stops;
    wr(OFS_CTRL, 8'h88);
    n = 0;
    while (agent.stops == st0 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    rd(OFS_DATA, 8'hFF, 8'hFF);
    chk(agent.stops == st0 + 1, "master rx stop");
    repeat (4) @(posedge sys_clk);
    $display("master receive done");
    wr(OFS_CTRL, 8'h80);
    agent.start_c();
    agent.byte_x(8'hA4, 1'b1, q, ack);
    chk(ack === 1'b0, "address ack");
    @(posedge sys_clk);
    wait_irq();
    rd(OFS_STATUS, 8'hC0, 8'hC4);
    wr(OFS_CTRL, 8'h80);
    rd(OFS_STATUS, 8'h00, 8'h40);
    wr(OFS_IRQ_ST, 8'h01);
    repeat (20) @(posedge sys_clk);
    chk(bus_oe.scl === 1'b1, "scl held");
    fork
      agent.byte_x(8'h3C, 1'b1, q, ack);
      rd(OFS_DATA, 8'h00, 8'h00);
    join
    @(posedge sys_clk);
    chk(ack === 1'b0, "data ack");
    wait_irq();
    rd(OFS_STATUS, 8'h80, 8'hC0);
    wr(OFS_IRQ_ST, 8'h01);
    rd(OFS_DATA, 8'h3C, 8'hFF);
    agent.start_c();
    agent.byte_x(8'hA5, 1'b1, q, ack);
    @(posedge sys_clk);
    wait_irq();
    rd(OFS_STATUS, 8'hC4, 8'hC4);
    wr(OFS_IRQ_ST, 8'h01);
    wr(OFS_CTRL, 8'h90);
    fork
      agent.byte_x(8'hFF, 1'b1, q, ack);
      wr(OFS_DATA, 8'h96);
    join
    @(posedge sys_clk);
    chk(q === 8'h96, "slave tx byte");
    wait_irq();
    rd(OFS_STATUS, 8'h01, 8'h01);
    wr(OFS_CTRL, 8'h80);
    fork
      agent.stop_c();
      rd(OFS_DATA, 8'h00, 8'h00);
    join
    repeat (5) @(posedge sys_clk);
    rd(OFS_STATUS, 8'h00, 8'h20);
    $display("slave done");
    report_and_stop();
  end
  initial begin
    #1000000;
    n_fail++;
    report_and_stop();
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
endmodule
`default_nettype wire
